// File: logic/dbx_unit.sv
// dbx_unit: breakpoint matching, fault/trap classification, status and resume flag
// assumes the pipeline presents a fetch before execution and a completed access after,
// and holds the instruction while exc.valid is raised
// Overview of operation
// - debug vector 1, software breakpoint vector 3
// - instruction and general detect are faults
// - one delivery may report fault and trap
// - type 0 slot matches executed instruction address
// - instruction hit raised before execution
// - instruction hit outranks other exceptions
// - instruction hit faults if enabled; its bit is set only when a delivery occurs
// - type 1 matches data writes, traps after
// - type 2 matches I/O accesses, traps
// - type 3 matches data reads and writes
// - protected register access sets flag, faults
// - range covers every byte of length
// - write slot ignores reads
// - unresolved instruction hit repeats on restart
// - resume flag suppresses instruction hits only
// - set resume before non-breakpoint faults
// - 32-bit return or task switch loads resume
// - restored resume skips exactly one instruction
// - flag pops and 16-bit return skip resume
// - two-bit type encoding
// - length masks low address bits
// - any touched byte in range hits
// - resume cleared after completed instruction
`timescale 1ns/100ps
module dbx_unit
   import dbx_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire dbx_pkg::dbx_fetch_t fetch,
   input wire dbx_pkg::dbx_access_t access,
   input wire logic other_fault,
   input wire logic sw_bkpt,
   input wire logic retire,
   input wire logic ret32,
   input wire logic task_sw,
   input wire logic flags_pop,
   input wire logic [31:0] flags_image,
   output dbx_pkg::dbx_exc_t exc,
   output logic resume_flag,
   output logic [3:0] slot_hit_flag
);
   import dbx_pkg::*;

   logic [31:0] bkpt_addr_slot [4];
   logic [31:0] debug_status_reg;
   logic [31:0] debug_control_reg;
   logic [3:0] next_ihit;
   logic [3:0] next_dhit;
   logic next_regacc;
   logic ifault;
   logic next_fault;
   logic next_trap;

   // mask of low address bits ignored by a slot length
   function automatic logic [31:0] len_mask(input logic [1:0] len);
      unique case (len)
         LEN_2: len_mask = 32'hFFFFFFFE;
         LEN_4: len_mask = 32'hFFFFFFFC;
         default: len_mask = 32'hFFFFFFFF;
      endcase
   endfunction : len_mask

   // true when any byte of [a, a+sz) lies in the slot range
   function automatic logic range_hit(input logic [31:0] base, input logic [1:0] len,
                                      input logic [31:0] a, input logic [2:0] sz);
      logic [31:0] lo;
      logic [31:0] hi;
      logic [31:0] alast;
      lo = base & len_mask(len);
      hi = lo | ~len_mask(len);
      alast = a + {29'h0, sz} - 32'h1;
      range_hit = (a <= hi) && (alast >= lo);
   endfunction : range_hit

   function automatic logic [1:0] slot_type(input logic [31:0] c, input int n);
      slot_type = c[CT_TYPE0 + 4*n +: 2];
   endfunction : slot_type

   function automatic logic slot_en(input logic [31:0] c, input int n);
      slot_en = c[2*n] | c[2*n+1];
   endfunction : slot_en

   always_comb begin
      for (int n = 0; n < 4; n++) begin
         next_ihit[n] = fetch.valid && !resume_flag
            && slot_type(debug_control_reg, n) == TYPE_EXEC
            && fetch.addr == bkpt_addr_slot[n];
         next_dhit[n] = 1'b0;
         if (access.valid) begin
            unique case (slot_type(debug_control_reg, n))
               TYPE_WRITE: next_dhit[n] = !access.is_io && access.is_write;
               TYPE_IO: next_dhit[n] = access.is_io;
               TYPE_RDWR: next_dhit[n] = !access.is_io;
               TYPE_EXEC: next_dhit[n] = 1'b0;
            endcase
            next_dhit[n] = next_dhit[n]
               && range_hit(bkpt_addr_slot[n], debug_control_reg[CT_TYPE0+4*n+2 +: 2],
                            access.addr, access.size);
         end
      end
      next_regacc = fetch.valid && fetch.drw && debug_control_reg[CT_GD];
      ifault = 1'b0;
      next_trap = 1'b0;
      for (int n = 0; n < 4; n++) begin
         ifault |= next_ihit[n] && slot_en(debug_control_reg, n);
         next_trap |= next_dhit[n] && slot_en(debug_control_reg, n);
      end
      next_fault = ifault || next_regacc;
   end

   // exception dispatch; any debug fault or trap wins over a software breakpoint
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         exc <= '0;
      end else begin
         exc <= '0;
         if (next_fault || next_trap) begin
            exc.valid <= 1'b1;
            exc.vector <= VEC_DEBUG;
            exc.fault <= next_fault;
            exc.trap <= next_trap;
         end else if (sw_bkpt) begin
            exc.valid <= 1'b1;
            exc.vector <= VEC_SWBKPT;
            exc.trap <= 1'b1;
         end
      end
   end

   // resume flag management
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         resume_flag <= 1'b0;
      end else if (ret32 || task_sw) begin
         resume_flag <= flags_image[FL_RESUME];
      end else if (other_fault && !ifault) begin
         resume_flag <= 1'b1;
      end else if (next_regacc && !ifault) begin
         resume_flag <= 1'b1;
      end else if (retire && !flags_pop) begin
         resume_flag <= 1'b0;
      end else if (retire) begin
         resume_flag <= 1'b0;
      end
   end

   // breakpoint address slots
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int n = 0; n < 4; n++) begin
            bkpt_addr_slot[n] <= RST_ZERO;
         end
      end else if (reg_wr) begin
         for (int n = 0; n < 4; n++) begin
            if (reg_addr == OFF_SLOT0 + 8'(4*n)) begin
               bkpt_addr_slot[n] <= reg_wdata;
            end
         end
      end
   end

   // control; protection bit drops on entering the handler
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_control_reg <= RST_CONTROL;
      end else if (next_fault || next_trap) begin
         debug_control_reg[CT_GD] <= 1'b0;
      end else if (reg_wr && reg_addr == OFF_CONTROL) begin
         debug_control_reg <= reg_wdata;
      end
   end

   // status loads hits on a delivery, else takes a status register write; a delivery wins over a same-cycle write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_status_reg <= RST_STATUS;
      end else if (next_fault || next_trap) begin
         debug_status_reg[3:0] <= next_ihit | next_dhit;
         debug_status_reg[ST_REGACC] <= debug_status_reg[ST_REGACC] | next_regacc;
      end else if (reg_wr && reg_addr == OFF_STATUS) begin
         debug_status_reg <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_hit_flag <= 4'h0;
      end else begin
         slot_hit_flag <= debug_status_reg[3:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= RST_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFF_SLOT0: reg_rdata <= bkpt_addr_slot[0];
            OFF_SLOT1: reg_rdata <= bkpt_addr_slot[1];
            OFF_SLOT2: reg_rdata <= bkpt_addr_slot[2];
            OFF_SLOT3: reg_rdata <= bkpt_addr_slot[3];
            OFF_STATUS: reg_rdata <= debug_status_reg;
            OFF_CONTROL: reg_rdata <= debug_control_reg;
            OFF_FLAGS: reg_rdata <= {15'h0, resume_flag, 16'h0};
            default: reg_rdata <= RST_ZERO;
         endcase
      end else begin
         reg_rdata <= RST_ZERO;
      end
   end

   // ---- assertions
   sequence s_ifault;
      fetch.valid && !resume_flag && next_fault && !next_regacc;
   endsequence
   property p_fault_vec;
      @(posedge core_clk) disable iff (!rst_n) s_ifault |=> exc.valid && exc.fault
         && exc.vector == VEC_DEBUG;
   endproperty
   a_fault_vec: assert property (p_fault_vec) else $error("instr hit not delivered");
   property p_trap;
      @(posedge core_clk) disable iff (!rst_n) next_trap |=> exc.trap && exc.valid;
   endproperty
   a_trap: assert property (p_trap) else $error("data hit not trapped");
   property p_resume_blocks;
      @(posedge core_clk) disable iff (!rst_n) resume_flag |-> next_ihit == 4'h0;
   endproperty
   a_resume_blocks: assert property (p_resume_blocks) else $error("hit under resume");
   property p_ret_load;
      @(posedge core_clk) disable iff (!rst_n) ret32 |=> resume_flag == $past(flags_image[FL_RESUME]);
   endproperty
   a_ret_load: assert property (p_ret_load) else $error("resume not loaded");
   property p_pop;
      @(posedge core_clk) disable iff (!rst_n)
         flags_pop && retire && !ret32 && !task_sw && !other_fault && !next_regacc |=> !resume_flag;
   endproperty
   a_pop: assert property (p_pop) else $error("pop moved resume");
   property p_regacc;
      @(posedge core_clk) disable iff (!rst_n) next_regacc |=> debug_status_reg[ST_REGACC]
         && exc.fault && !debug_control_reg[CT_GD];
   endproperty
   a_regacc: assert property (p_regacc) else $error("reg access not faulted");
   property p_sw;
      @(posedge core_clk) disable iff (!rst_n) sw_bkpt && !next_fault && !next_trap
         |=> exc.vector == VEC_SWBKPT;
   endproperty
   a_sw: assert property (p_sw) else $error("sw breakpoint vector");
   property p_ofault;
      @(posedge core_clk) disable iff (!rst_n) other_fault && !ifault && !ret32 && !task_sw
         |=> resume_flag;
   endproperty
   a_ofault: assert property (p_ofault) else $error("resume not set");

   // a delivery of any debug condition in this cycle
   sequence s_delivery;
      next_fault || next_trap;
   endsequence
   // a trap with no fault condition beside it
   sequence s_trap_only;
      next_trap && !next_fault;
   endsequence
   // both classes at once
   sequence s_both;
      next_fault && next_trap;
   endsequence

   property p_exc_vec;
      @(posedge core_clk) disable iff (!rst_n)
         exc.valid |-> exc.vector == VEC_DEBUG || exc.vector == VEC_SWBKPT;
   endproperty
   a_exc_vec: assert property (p_exc_vec) else $error("bad exception vector");
   property p_trap_class;
      @(posedge core_clk) disable iff (!rst_n)
         s_trap_only |=> exc.valid && exc.trap && !exc.fault;
   endproperty
   a_trap_class: assert property (p_trap_class) else $error("data hit raised as fault");
   property p_both;
      @(posedge core_clk) disable iff (!rst_n) s_both |=> exc.valid && exc.fault && exc.trap;
   endproperty
   a_both: assert property (p_both) else $error("fault and trap not reported together");
   property p_quiet;
      @(posedge core_clk) disable iff (!rst_n)
         !next_fault && !next_trap && !sw_bkpt |=> !exc.valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("exception without a cause");
   property p_status_copy;
      @(posedge core_clk) disable iff (!rst_n)
         s_delivery |=> debug_status_reg[3:0] == $past(next_ihit | next_dhit);
   endproperty
   a_status_copy: assert property (p_status_copy) else $error("slot status not recorded");
   property p_hit_copy;
      @(posedge core_clk) disable iff (!rst_n)
         1'b1 |=> slot_hit_flag == $past(debug_status_reg[3:0]);
   endproperty
   a_hit_copy: assert property (p_hit_copy) else $error("slot hit copy stale");
   property p_gd_clear;
      @(posedge core_clk) disable iff (!rst_n) s_delivery |=> !debug_control_reg[CT_GD];
   endproperty
   a_gd_clear: assert property (p_gd_clear) else $error("protection kept in handler");
   property p_ihit_keep;
      @(posedge core_clk) disable iff (!rst_n)
         ifault && !ret32 && !task_sw && !retire |=> resume_flag == $past(resume_flag);
   endproperty
   a_ihit_keep: assert property (p_ihit_keep) else $error("resume moved by instr hit");
   property p_regacc_resume;
      @(posedge core_clk) disable iff (!rst_n)
         next_regacc && !ifault && !ret32 && !task_sw |=> resume_flag;
   endproperty
   a_regacc_resume: assert property (p_regacc_resume) else $error("resume not set on detect");
   property p_tsw_load;
      @(posedge core_clk) disable iff (!rst_n)
         task_sw && !ret32 |=> resume_flag == $past(flags_image[FL_RESUME]);
   endproperty
   a_tsw_load: assert property (p_tsw_load) else $error("resume not loaded on switch");
   property p_retire_clear;
      @(posedge core_clk) disable iff (!rst_n)
         retire && !ret32 && !task_sw && !other_fault && !next_regacc |=> !resume_flag;
   endproperty
   a_retire_clear: assert property (p_retire_clear) else $error("resume kept after retire");
endmodule : dbx_unit

// File: logic/dbx_pkg.sv
// dbx_pkg: constants and carrier types for the debug exception breakpoint unit
// assumes a single core clock; all users import dbx_pkg::*
package dbx_pkg;
   localparam logic [7:0] VEC_DEBUG = 8'h01;
   localparam logic [7:0] VEC_SWBKPT = 8'h03;
   localparam logic [1:0] TYPE_EXEC = 2'h0;
   localparam logic [1:0] TYPE_WRITE = 2'h1;
   localparam logic [1:0] TYPE_IO = 2'h2;
   localparam logic [1:0] TYPE_RDWR = 2'h3;
   localparam logic [1:0] LEN_1 = 2'h0;
   localparam logic [1:0] LEN_2 = 2'h1;
   localparam logic [1:0] LEN_4 = 2'h3;
   // register offsets (word index in byte address = index*4)
   localparam logic [7:0] OFF_SLOT0 = 8'h00;
   localparam logic [7:0] OFF_SLOT1 = 8'h04;
   localparam logic [7:0] OFF_SLOT2 = 8'h08;
   localparam logic [7:0] OFF_SLOT3 = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_CONTROL = 8'h1C;
   localparam logic [7:0] OFF_FLAGS = 8'h20;
   // status field positions
   localparam int ST_REGACC = 13;
   localparam int ST_STEP = 14;
   localparam int ST_TASK = 15;
   // control field positions
   localparam int CT_GD = 13;
   localparam int CT_TYPE0 = 16;
   // flags register: resume flag position
   localparam int FL_RESUME = 16;
   localparam logic [31:0] RST_STATUS = 32'hFFFF0FF0;
   localparam logic [31:0] RST_CONTROL = 32'h00000400;
   localparam logic [31:0] RST_ZERO = 32'h00000000;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic drw;   // debug register access instruction
   } dbx_fetch_t;

   typedef struct packed {
      logic valid;
      logic is_io;
      logic is_write;
      logic [31:0] addr;
      logic [2:0] size;   // bytes touched: 1, 2 or 4
   } dbx_access_t;

   typedef struct packed {
      logic valid;
      logic [7:0] vector;
      logic fault;
      logic trap;
   } dbx_exc_t;
endpackage : dbx_pkg

// File: tb/dbx_pipe_model.sv
// dbx_pipe_model: pipeline stand-in feeding fetches, accesses and event pulses
// assumes op is entered just after a rising core_clk edge
`timescale 1ns/100ps
module dbx_pipe_model
   import dbx_pkg::*;
(
   input wire logic core_clk,
   output dbx_pkg::dbx_fetch_t fetch,
   output dbx_pkg::dbx_access_t access,
   output logic [5:0] pulse,
   output logic [31:0] flags_image
);
   initial begin
      fetch = '0;
      access = '0;
      pulse = 6'h0;
      flags_image = 32'h0;
   end
   // released lines clear valid and pulses and carry inverted addresses, access kind and flags image so stale data never looks valid
   task automatic op(input dbx_fetch_t f, input dbx_access_t a, input logic [5:0] p,
                     input logic [31:0] img);
      fetch <= f;
      access <= a;
      pulse <= p;
      flags_image <= img;
      @(posedge core_clk);
      fetch <= '{1'b0, ~f.addr, 1'b0};
      access <= '{1'b0, ~a.is_io, ~a.is_write, ~a.addr, 3'h1};
      pulse <= 6'h0;
      flags_image <= ~img;
   endtask : op
endmodule : dbx_pipe_model

// File: tb/tb.sv
// tb: self-checking bench for dbx_unit driven through a pipeline model
// assumes the dbx_pkg register map and a 25 MHz core clock
`timescale 1ns/100ps
module tb;
   import dbx_pkg::*;
   localparam logic [5:0] RET = 6'h01, R32 = 6'h02, TSW = 6'h04, POP = 6'h08, FLT = 6'h10;
   localparam logic [31:0] IMG = 32'h00010000;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, flags_image, ctrl_m, r, c;
   logic [31:0] slot_m [4];
   logic [5:0] pulse;
   logic resume_flag;
   logic [3:0] slot_hit_flag;
   dbx_fetch_t fetch;
   dbx_access_t access;
   dbx_exc_t exc;
   int miscompares = 0;
   int compares = 0;
   int seed = 32'hc9c3;
   logic [27:0] tbl [18] = '{28'h09A0001, 28'h0AA0001, 28'h09A0002, 28'h0AB0002, 28'h0CB0002,
      28'h09B0002, 28'h09C0000, 28'h0AC0000, 28'h0CC0000, 28'h0AC0001, 28'h09C0003, 28'h09A0000,
      28'h01A0002, 28'h0CA0003, 28'h0AB0000, 28'h02C0000, 28'h04C0000, 28'h19A0001};
   always #20 core_clk = ~core_clk;
   dbx_pipe_model pm (.core_clk(core_clk), .fetch(fetch), .access(access), .pulse(pulse),
      .flags_image(flags_image));
   dbx_unit uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fetch(fetch), .access(access), .other_fault(pulse[4]), .sw_bkpt(pulse[5]),
      .retire(pulse[0]), .ret32(pulse[1]), .task_sw(pulse[2]), .flags_pop(pulse[3]),
      .flags_image(flags_image), .exc(exc), .resume_flag(resume_flag),
      .slot_hit_flag(slot_hit_flag));
   task automatic give_verdict();
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      if (a == OFF_CONTROL) ctrl_m = d;
      if (a < 8'h10) slot_m[a[3:2]] = d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check("reg_rdata", reg_rdata, exp);
      @(posedge core_clk);
   endtask : rd
   task automatic rf(input logic e);
      #1 check("resume_flag", {31'h0, resume_flag}, {31'h0, e});
      @(posedge core_clk);
   endtask : rf
   function automatic dbx_fetch_t fe(input logic [31:0] a, input logic d);
      return '{1'b1, a, d};
   endfunction : fe
   function automatic dbx_exc_t exv(input logic f, input logic t);
      return '{1'b1, VEC_DEBUG, f, t};
   endfunction : exv
   // exc must follow the cause by one cycle, the hit copy one cycle later
   task automatic step(input dbx_fetch_t f, input dbx_access_t a, input logic [5:0] p,
                       input logic [31:0] img, input dbx_exc_t ex, input logic [3:0] hf);
      pm.op(f, a, p, img);
      #1;
      if (ex.valid) check("exc", {21'h0, exc}, {21'h0, ex});
      else check("exc_valid", {31'h0, exc.valid}, 32'h0);
      @(posedge core_clk);
      #1;
      if (ex.valid) check("slot_hit_flag", {28'h0, slot_hit_flag}, {28'h0, hf});
      @(posedge core_clk);
   endtask : step
   function automatic logic [3:0] exp_hits(input dbx_access_t a);
      logic [3:0] h;
      logic [1:0] ty, ln;
      logic [31:0] lo;
      h = 4'h0;
      for (int n = 0; n < 4; n++) begin
         ty = ctrl_m[16 + 4 * n +: 2];
         ln = ctrl_m[18 + 4 * n +: 2];
         lo = slot_m[n] & ~{30'h0, ln};
         if ((a.is_io ? ty == TYPE_IO : (ty == TYPE_RDWR || (ty == TYPE_WRITE && a.is_write)))
             && a.addr <= lo + {30'h0, ln} && a.addr + {29'h0, a.size} - 32'h1 >= lo) h[n] = 1'b1;
      end
      return h;
   endfunction : exp_hits
   task automatic acc(input dbx_access_t a);
      logic [3:0] h;
      h = exp_hits(a);
      step('0, a, 6'h0, 32'h0,
           |(h & {|ctrl_m[7:6], |ctrl_m[5:4], |ctrl_m[3:2], |ctrl_m[1:0]}) ? exv(1'b0, 1'b1) : '0, h);
   endtask : acc
   initial begin
      repeat (5000) @(posedge core_clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(OFF_STATUS, RST_STATUS);
      rd(OFF_CONTROL, RST_CONTROL);
      rd(OFF_FLAGS, RST_ZERO);
      rd(OFF_SLOT0, RST_ZERO);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, RST_ZERO);
      wr(OFF_SLOT0, 32'hA0001);
      wr(OFF_SLOT1, 32'hA0002);
      wr(OFF_SLOT2, 32'hB0002);
      wr(OFF_SLOT3, 32'hC0000);
      wr(OFF_CONTROL, 32'hD71304AA);
      foreach (tbl[i]) acc('{1'b1, tbl[i][24], tbl[i][23], {12'h0, tbl[i][19:0]}, tbl[i][22:20]});
      for (int k = 0; k < 60; k++) begin
         if (k % 20 == 0) begin
            r = $random(seed);
            c = 32'h4AA;
            for (int n = 0; n < 4; n++) begin
               wr(OFF_SLOT0 + 8'(4 * n), ($random(seed) & 32'hFFF0) | 32'h10);
               rd(OFF_SLOT0 + 8'(4 * n), slot_m[n]);
               c[16 + 4 * n +: 4] = {r[8 + n], r[8 + n] | r[12 + n], r[n], r[4 + n] | ~r[n]};
            end
            wr(OFF_CONTROL, c);
            rd(OFF_CONTROL, c);
         end
         r = $random(seed);
         acc('{1'b1, r[8], r[9], slot_m[r[1:0]] + {29'h0, r[4:2]} - 32'h4, r[7] ? 3'h4 : {1'b0, r[6], ~r[6]}});
      end
      wr(OFF_SLOT0, 32'h2000);
      wr(OFF_SLOT1, 32'h1000);
      wr(OFF_SLOT2, 32'hFFFF0000);
      wr(OFF_SLOT3, 32'hFFFF0000);
      wr(OFF_CONTROL, 32'h33010406);
      step(fe(32'h1000, 1'b0), '0, 6'h0, 32'h0, exv(1'b1, 1'b0), 4'h2);
      step(fe(32'h1000, 1'b0), '0, 6'h0, 32'h0, exv(1'b1, 1'b0), 4'h2);
      rf(1'b0);
      step('0, '0, R32, IMG, '0, 4'h0);
      rf(1'b1);
      rd(OFF_FLAGS, IMG);
      step(fe(32'h1000, 1'b0), '{1'b1, 1'b0, 1'b1, 32'h2000, 3'h1}, RET, 32'h0, exv(1'b0, 1'b1), 4'h1);
      rf(1'b0);
      step(fe(32'h1000, 1'b0), '{1'b1, 1'b0, 1'b1, 32'h1FFF, 3'h2}, 6'h0, 32'h0, exv(1'b1, 1'b1), 4'h3);
      step('0, '0, POP, IMG, '0, 4'h0);
      rf(1'b0);
      step('0, '0, TSW, IMG, '0, 4'h0);
      rf(1'b1);
      step('0, '0, RET, 32'h0, '0, 4'h0);
      rf(1'b0);
      step('0, '0, FLT, 32'h0, '0, 4'h0);
      rf(1'b1);
      step(fe(32'h1000, 1'b0), '0, RET, 32'h0, '0, 4'h0);
      step(fe(32'h1000, 1'b0), '0, FLT, 32'h0, exv(1'b1, 1'b0), 4'h2);
      rf(1'b0);
      step('0, '0, RET, 32'h0, '0, 4'h0);
      pm.op('0, '0, 6'h20, 32'h0);
      #1 check("exc_vector", {23'h0, exc.valid, exc.vector}, {23'h0, 1'b1, VEC_SWBKPT});
      @(posedge core_clk);
      wr(OFF_CONTROL, 32'h33012406);
      step(fe(32'h5000, 1'b1), '0, 6'h0, 32'h0, exv(1'b1, 1'b0), 4'h0);
      rd(OFF_STATUS, RST_STATUS | 32'h2000);
      rd(OFF_CONTROL, 32'h33010406);
      give_verdict();
   end
endmodule : tb
